// file: inc/sse_pkg.sv
// constants and types for the store and subtract execute datapath
// Functional notes
// - dual float store writes both memory words in one cycle as float words
// - dual store sources are registers 0..7; destinations are indirect addresses
// - integer store writes any register 0..27 to memory as signed integer
// - single store address mode 01 is direct, 10 is indirect
// - interlocked integer store writes memory and signals end on both flag pins
// - dual integer store to one address keeps the second-listed source value
// - stores and conditional subtract leave flags alone and ignore saturate mode
// - two-operand form: dst minus src minus carry into dst, signed
// - three-operand form: src1 minus src2 minus carry into separate dst
// - three-operand mode 00 both registers, 10 register then indirect
// - flags change only for dst R0..R7; underflow cleared, latched underflow kept
// - latched overflow set on overflow, otherwise held
// - overflow flag set on overflow, cleared otherwise
// - negative and zero flags follow the result
// - carry flag set on borrow, cleared otherwise
// - subtract-with-borrow result depends on saturate mode
// - conditional subtract: nonnegative difference shifted left with bit 0 set
// - conditional subtract: negative difference keeps dst shifted left
// - conditional subtract treats operands as unsigned
package sse_pkg;
   localparam int DATA_W = 32;
   localparam int REG_W = 5;
   localparam int ADDR_W = 24;
   localparam logic [4:0] LAST_REG = 5'h1B;
   localparam logic [4:0] LAST_EXT_REG = 5'h07;
   localparam logic [1:0] MODE_DIRECT = 2'h1;
   localparam logic [1:0] MODE_INDIRECT = 2'h2;
   localparam logic [1:0] T_REG_REG = 2'h0;
   localparam logic [1:0] T_REG_IND = 2'h2;
   localparam int FLAG_HOLD_NS = 200;
   localparam int CLK_NS = 40;
   localparam int FLAG_HOLD_CYC = (FLAG_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [DATA_W-1:0] MAX_POS = 32'h7FFFFFFF;
   localparam logic [DATA_W-1:0] MAX_NEG = 32'h80000000;

   typedef enum logic [2:0] {
      OP_NONE, OP_FLOAT_STORE_DUAL, OP_INT_STORE, OP_INT_STORE_INTERLOCKED,
      OP_INT_STORE_DUAL, OP_SUB_WITH_BORROW, OP_SUB_WITH_BORROW_THREE_OP,
      OP_CONDITIONAL_SUB_SHIFT
   } sse_op_t;

   typedef struct packed {
      logic latched_underflow_flag;
      logic latched_overflow_flag;
      logic underflow_flag;
      logic neg;
      logic zero;
      logic ovf;
      logic carry;
   } sse_flags_t;

   typedef struct packed {
      logic we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } sse_mem_wr_t;
endpackage

// file: logic/sse_exec.sv
// execute-stage datapath for stores, subtract-with-borrow and conditional subtract
module sse_exec
   import sse_pkg::*;
#(
   parameter int HOLD_CYC = FLAG_HOLD_CYC
) (
   input wire logic ref_clk_i,                 // processor clock
   input wire logic rst_n_i,                   // synchronous reset, active low
   input wire logic valid_i,                   // instruction present this cycle
   input wire sse_op_t op_i,                   // decoded operation
   input wire logic [1:0] mode_i,              // store G field or three-operand T field
   input wire logic [REG_W-1:0] dst_reg_i,     // destination register number
   input wire logic [REG_W-1:0] src1_reg_i,    // first source register number
   input wire logic [REG_W-1:0] src2_reg_i,    // second source register number
   input wire logic [DATA_W-1:0] src1_val_i,   // first source operand value
   input wire logic [DATA_W-1:0] src2_val_i,   // second source value (memory if indirect)
   input wire logic [DATA_W-1:0] dst_val_i,    // current destination register value
   input wire logic [ADDR_W-1:0] addr1_i,      // first store address
   input wire logic [ADDR_W-1:0] addr2_i,      // second store address
   input wire logic overflow_saturate_mode_i,  // saturate on integer overflow
   input wire sse_flags_t flags_i,             // current condition flags
   output sse_mem_wr_t mem_wr1_o,              // first memory write port
   output sse_mem_wr_t mem_wr2_o,              // second memory write port
   output logic mem_float_o,                   // stored words are floating point
   output logic reg_we_o,                      // register write strobe
   output logic [REG_W-1:0] reg_waddr_o,       // register written
   output logic [DATA_W-1:0] reg_wdata_o,      // register write data
   output sse_flags_t flags_o,                 // updated condition flags
   output logic flags_we_o,                    // flag update strobe
   output logic illegal_o,                     // operand outside allowed range
   output logic ext_flag_pin_a_o,              // interlock flag pin a
   output logic ext_flag_pin_b_o               // interlock flag pin b
);
   // a zero hold cannot be met, as the pins stay up at least one cycle, so refuse it while elaborating
   if (HOLD_CYC < 1) begin : g_hold_check
      $error("HOLD_CYC must be at least 1");
   end

   wire is_dual = (op_i == OP_FLOAT_STORE_DUAL) || (op_i == OP_INT_STORE_DUAL);
   wire is_single = (op_i == OP_INT_STORE) || (op_i == OP_INT_STORE_INTERLOCKED);
   wire is_sub_with_borrow = (op_i == OP_SUB_WITH_BORROW) || (op_i == OP_SUB_WITH_BORROW_THREE_OP);
   wire is_conditional_sub_shift = (op_i == OP_CONDITIONAL_SUB_SHIFT);

   wire dual_bad = is_dual && ((src1_reg_i > LAST_EXT_REG) || (src2_reg_i > LAST_EXT_REG));
   wire single_bad = is_single && (mode_i != MODE_DIRECT) && (mode_i != MODE_INDIRECT);
   wire three_bad = (op_i == OP_SUB_WITH_BORROW_THREE_OP)
      && (mode_i != T_REG_REG) && (mode_i != T_REG_IND);
   // stores carry no destination register, so that field is ignored for them
   wire reg_bad = (src1_reg_i > LAST_REG)
      || ((is_sub_with_borrow || is_conditional_sub_shift) && (dst_reg_i > LAST_REG))
      || ((op_i == OP_SUB_WITH_BORROW_THREE_OP) && (mode_i == T_REG_REG)
      && (src2_reg_i > LAST_REG));
   wire bad = dual_bad || single_bad || three_bad || reg_bad;
   wire go = valid_i && !bad;

   // two-operand form takes dst as minuend
   // three-operand form takes src1 as minuend
   wire [DATA_W-1:0] minuend = (op_i == OP_SUB_WITH_BORROW) ? dst_val_i : src1_val_i;
   wire [DATA_W-1:0] subtrahend = (op_i == OP_SUB_WITH_BORROW) ? src1_val_i : src2_val_i;
   wire [DATA_W:0] wide_diff = {1'b0, minuend} - {1'b0, subtrahend}
      - {{DATA_W{1'b0}}, flags_i.carry};
   wire [DATA_W-1:0] raw_diff = wide_diff[DATA_W-1:0];
   // borrow out of the unsigned subtraction
   wire borrow = wide_diff[DATA_W];
   wire ovf = (minuend[DATA_W-1] != subtrahend[DATA_W-1])
      && (raw_diff[DATA_W-1] != minuend[DATA_W-1]);
   wire [DATA_W-1:0] sat_val = minuend[DATA_W-1] ? MAX_NEG : MAX_POS;
   wire [DATA_W-1:0] sub_with_borrow_res = (ovf && overflow_saturate_mode_i) ? sat_val : raw_diff;

   wire [DATA_W:0] c_diff = {1'b0, dst_val_i} - {1'b0, src1_val_i};
   wire c_ge = !c_diff[DATA_W];
   // shifted difference with bit 0 set when nonnegative, else dst shifted left with bit 0 clear
   wire [DATA_W-1:0] conditional_sub_shift_res = c_ge ? {c_diff[DATA_W-2:0], 1'b1}
      : {dst_val_i[DATA_W-2:0], 1'b0};

   wire flag_upd = go && is_sub_with_borrow && (dst_reg_i <= LAST_EXT_REG);
   sse_flags_t next_flags;
   always_comb begin
      next_flags = flags_i;
      next_flags.underflow_flag = 1'b0;
      next_flags.latched_overflow_flag = flags_i.latched_overflow_flag | ovf;
      next_flags.ovf = ovf;
      // sign and zero of stored result
      next_flags.neg = sub_with_borrow_res[DATA_W-1];
      next_flags.zero = (sub_with_borrow_res == '0);
      next_flags.carry = borrow;
   end

   // second-listed store wins on equal address
   wire same_addr = (addr1_i == addr2_i);

   sse_mem_wr_t next_wr1;
   sse_mem_wr_t next_wr2;
   always_comb begin
      next_wr1 = '0;
      next_wr2 = '0;
      if (go && is_dual) begin
         // both writes issued in the same cycle, except the first for a dual integer store to one address
         next_wr1.we = !(op_i == OP_INT_STORE_DUAL && same_addr);
         next_wr1.addr = addr1_i;
         next_wr1.data = src1_val_i;
         next_wr2.we = 1'b1;
         next_wr2.addr = addr2_i;
         next_wr2.data = src2_val_i;
      end else if (go && is_single) begin
         next_wr1.we = 1'b1;
         next_wr1.addr = addr1_i;
         next_wr1.data = src1_val_i;
      end
   end

   wire lock_end = go && (op_i == OP_INT_STORE_INTERLOCKED);
   localparam int HOLD_W = $clog2(HOLD_CYC + 1);
   localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_CYC - 1);
   logic [HOLD_W-1:0] hold_cnt;
   logic pin_lvl;

   // every result leaves through a flop so memory and register file see one clean edge
   wire next_mem_float = go && (op_i == OP_FLOAT_STORE_DUAL);
   wire next_reg_we = go && (is_sub_with_borrow || is_conditional_sub_shift);
   wire [DATA_W-1:0] next_reg_wdata = is_conditional_sub_shift ? conditional_sub_shift_res : sub_with_borrow_res;
   // stores and conditional subtract pass flags through
   sse_flags_t next_flags_out;
   assign next_flags_out = flag_upd ? next_flags : flags_i;
   wire next_illegal = valid_i && bad;
   // pins stay up while the counter runs
   wire next_pin_lvl = lock_end || (pin_lvl && (hold_cnt != '0));

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         mem_wr1_o <= '0;
         mem_wr2_o <= '0;
      end else begin
         mem_wr1_o <= next_wr1;
         mem_wr2_o <= next_wr2;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         mem_float_o <= 1'b0;
      end else begin
         mem_float_o <= next_mem_float;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         reg_we_o <= 1'b0;
         reg_waddr_o <= '0;
         reg_wdata_o <= '0;
      end else begin
         reg_we_o <= next_reg_we;
         reg_waddr_o <= dst_reg_i;
         reg_wdata_o <= next_reg_wdata;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         flags_o <= '0;
         flags_we_o <= 1'b0;
      end else begin
         flags_o <= next_flags_out;
         flags_we_o <= flag_upd;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         illegal_o <= 1'b0;
      end else begin
         illegal_o <= next_illegal;
      end
   end

   // hold restarts on a new request
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         hold_cnt <= '0;
      end else if (lock_end) begin
         hold_cnt <= HOLD_LOAD;
      end else if (hold_cnt != '0) begin
         hold_cnt <= hold_cnt - 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         pin_lvl <= 1'b0;
      end else begin
         pin_lvl <= next_pin_lvl;
      end
   end

   // both pins carry the same level so the partner may watch either
   assign ext_flag_pin_a_o = pin_lvl;
   assign ext_flag_pin_b_o = pin_lvl;
endmodule

// file: bench/sse_mem_model.sv
// data memory and interlock observer on the far side of the store ports
module sse_mem_model
   import sse_pkg::*;
(
   input wire logic ref_clk_i, // processor clock
   input wire sse_mem_wr_t mem_wr1_i, // first store port
   input wire sse_mem_wr_t mem_wr2_i, // second store port
   input wire logic pin_a_i, // interlock flag pin a
   input wire logic pin_b_i, // interlock flag pin b
   input wire logic [7:0] rd_addr_i, // peek address
   output logic [DATA_W-1:0] rd_data_o, // peek data
   output logic [3:0] pin_run_o // length of the last flag pulse
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [DATA_W-1:0] mem [256];
   logic seen;
   assign rd_data_o = mem[rd_addr_i];
   always_ff @(posedge ref_clk_i) begin
      if (mem_wr1_i.we)
         mem[mem_wr1_i.addr[7:0]] <= mem_wr1_i.data;
      if (mem_wr2_i.we)
         mem[mem_wr2_i.addr[7:0]] <= mem_wr2_i.data;
   end
   always_ff @(posedge ref_clk_i) begin
      seen <= pin_a_i & pin_b_i;
      if (pin_a_i & pin_b_i)
         pin_run_o <= seen ? pin_run_o + 4'h1 : 4'h1;
   end
endmodule

// file: bench/sse_exec_checker.sv
// assertions on the store and subtract datapath ports
module sse_exec_checker
   import sse_pkg::*;
#(
   parameter int HOLD_CYC = 5
) (
   input wire logic ref_clk_i, // clock
   input wire logic rst_n_i, // reset
   input wire logic valid_i, // valid
   input wire sse_op_t op_i, // operation
   input wire logic [1:0] mode_i, // mode field
   input wire logic [REG_W-1:0] dst_reg_i, // dst register
   input wire logic [REG_W-1:0] src1_reg_i, // src register
   input wire logic [ADDR_W-1:0] addr1_i, // address 1
   input wire logic [ADDR_W-1:0] addr2_i, // address 2
   input wire sse_flags_t flags_i, // flags in
   input wire sse_mem_wr_t mem_wr1_o, // write 1
   input wire sse_mem_wr_t mem_wr2_o, // write 2
   input wire logic mem_float_o, // float words
   input wire logic [DATA_W-1:0] reg_wdata_o, // result
   input wire sse_flags_t flags_o, // flags out
   input wire logic flags_we_o, // flag strobe
   input wire logic ext_flag_pin_a_o, // pin a
   input wire logic ext_flag_pin_b_o // pin b
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt;
   wire logic int_store_interlocked = valid_i && op_i == OP_INT_STORE_INTERLOCKED && src1_reg_i <= LAST_REG
      && (mode_i == MODE_DIRECT || mode_i == MODE_INDIRECT);
   // restart on every new interlocked store, as the pins do
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i)
         cnt <= 8'h0;
      else if (int_store_interlocked)
         cnt <= 8'h1;
      else if (cnt != 8'h0)
         cnt <= (cnt == 8'(HOLD_CYC)) ? 8'h0 : cnt + 8'h1;
   end
   default clocking @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   AST_NO_FLAGS: assert property (valid_i && op_i inside {OP_FLOAT_STORE_DUAL,
      OP_INT_STORE, OP_INT_STORE_INTERLOCKED, OP_INT_STORE_DUAL, OP_CONDITIONAL_SUB_SHIFT}
      |=> !flags_we_o) else $error("flag strobe after store");
   AST_HIGH_DST: assert property (valid_i && dst_reg_i > LAST_EXT_REG &&
      op_i inside {OP_SUB_WITH_BORROW, OP_SUB_WITH_BORROW_THREE_OP} |=> !flags_we_o)
      else $error("flags updated for high destination");
   AST_UF_CLEAR: assert property (flags_we_o |-> !flags_o.underflow_flag &&
      flags_o.latched_underflow_flag == $past(flags_i.latched_underflow_flag))
      else $error("underflow flags wrong");
   AST_LV_STICKY: assert property (flags_we_o |-> flags_o.latched_overflow_flag ==
      ($past(flags_i.latched_overflow_flag) | flags_o.ovf)) else $error("latched overflow wrong");
   AST_NZ: assert property (flags_we_o |-> flags_o.zero == (reg_wdata_o == 32'h0) &&
      flags_o.neg == reg_wdata_o[31]) else $error("negative or zero flag wrong");
   AST_DUAL_SAME: assert property (valid_i && op_i == OP_INT_STORE_DUAL &&
      addr1_i == addr2_i |=> !mem_wr1_o.we) else $error("first store not dropped");
   AST_FLOAT_PAIR: assert property (mem_float_o |-> mem_wr1_o.we && mem_wr2_o.we)
      else $error("dual float store not paired");
   AST_PINS: assert property (ext_flag_pin_a_o == ext_flag_pin_b_o &&
      ext_flag_pin_a_o == (cnt != 8'h0)) else $error("flag pin hold wrong");
   AST_INT_STORE_INTERLOCKED_WRITE: assert property (int_store_interlocked |=> mem_wr1_o.we)
      else $error("interlocked store did not write");
endmodule
bind sse_exec sse_exec_checker #(.HOLD_CYC(HOLD_CYC)) i_chk (.*);

// file: bench/tb_top.sv
// self-checking bench for the store and subtract execute datapath
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import sse_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic valid_i = 1'b0;
   logic overflow_saturate_mode_i = 1'b0;
   sse_op_t op_i = OP_NONE;
   logic [1:0] mode_i = 2'h0;
   logic [REG_W-1:0] dst_reg_i = 5'h0, src1_reg_i = 5'h0, src2_reg_i = 5'h0, reg_waddr_o;
   logic [DATA_W-1:0] src1_val_i = 32'h0, src2_val_i = 32'h0, dst_val_i = 32'h0;
   logic [DATA_W-1:0] reg_wdata_o, rd;
   logic [ADDR_W-1:0] addr1_i = 24'h0, addr2_i = 24'h0;
   sse_flags_t flags_i = 7'h0, flags_o;
   sse_mem_wr_t mem_wr1_o, mem_wr2_o;
   logic mem_float_o, reg_we_o, flags_we_o, illegal_o, ext_flag_pin_a_o, ext_flag_pin_b_o;
   logic [3:0] run;
   int n_mismatch = 0, n_checks = 0, cyc = 0;
   sse_exec #(.HOLD_CYC(3)) i_dut (.*);
   sse_mem_model i_mem (.ref_clk_i, .mem_wr1_i(mem_wr1_o), .mem_wr2_i(mem_wr2_o),
      .pin_a_i(ext_flag_pin_a_o), .pin_b_i(ext_flag_pin_b_o), .rd_addr_i(addr2_i[7:0]),
      .rd_data_o(rd), .pin_run_o(run));
   initial forever #20 ref_clk_i = ~ref_clk_i;
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one instruction, launched at a falling edge, results read one cycle later
   task automatic go(input sse_op_t o, input logic [1:0] m, input logic [4:0] d, s, t,
      input logic [31:0] x, y, z);
      op_i = o;
      mode_i = m;
      dst_reg_i = d;
      src1_reg_i = s;
      src2_reg_i = t;
      src1_val_i = x;
      src2_val_i = y;
      dst_val_i = z;
      // valid stays up so back-to-back calls never toggle it within one step
      valid_i = 1'b1;
      @(negedge ref_clk_i);
   endtask
   task automatic sub_chk(input logic [31:0] res, input logic [6:0] fl, input logic we);
      chk(reg_wdata_o, res);
      chk(flags_o, fl);
      chk(flags_we_o, we);
      chk({reg_we_o, illegal_o}, 2'h2);
   endtask
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 2000) begin
         n_mismatch++;
         conclude();
      end
   end
   initial begin
      repeat (8) @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      flags_i = 7'h01;
      go(OP_SUB_WITH_BORROW, 2'h0, 5'h02, 5'h05, 5'h0, 32'hC7, 32'h0, 32'hFA);
      sub_chk(32'h32, 7'h00, 1'b1);
      chk(reg_waddr_o, 32'h2);
      flags_i = 7'h00;
      go(OP_SUB_WITH_BORROW, 2'h0, 5'h00, 5'h01, 5'h0, 32'h1, 32'h0, 32'h0);
      sub_chk(32'hFFFFFFFF, 7'h09, 1'b1);
      go(OP_SUB_WITH_BORROW, 2'h0, 5'h03, 5'h05, 5'h0, 32'h5, 32'h0, 32'h5);
      sub_chk(32'h0, 7'h04, 1'b1);
      go(OP_SUB_WITH_BORROW, 2'h0, 5'h01, 5'h02, 5'h0, 32'h1, 32'h0, 32'h80000000);
      sub_chk(32'h7FFFFFFF, 7'h22, 1'b1);
      overflow_saturate_mode_i = 1'b1;
      go(OP_SUB_WITH_BORROW, 2'h0, 5'h01, 5'h02, 5'h0, 32'h1, 32'h0, 32'h80000000);
      sub_chk(32'h80000000, 7'h2A, 1'b1);
      overflow_saturate_mode_i = 1'b0;
      flags_i = 7'h20;
      go(OP_SUB_WITH_BORROW, 2'h0, 5'h01, 5'h02, 5'h0, 32'h1, 32'h0, 32'h5);
      sub_chk(32'h4, 7'h20, 1'b1);
      flags_i = 7'h51;
      go(OP_SUB_WITH_BORROW_THREE_OP, T_REG_REG, 5'h04, 5'h07, 5'h02, 32'h866, 32'h834, 32'h0);
      sub_chk(32'h31, 7'h40, 1'b1);
      go(OP_SUB_WITH_BORROW_THREE_OP, T_REG_IND, 5'h09, 5'h01, 5'h02, 32'h5, 32'h7, 32'h0);
      sub_chk(32'hFFFFFFFD, 7'h51, 1'b0);
      chk(reg_waddr_o, 32'h9);
      $display("subtract tests done");
      go(OP_CONDITIONAL_SUB_SHIFT, 2'h0, 5'h01, 5'h02, 5'h0, 32'h492, 32'h0, 32'h4F6);
      sub_chk(32'hC9, 7'h51, 1'b0);
      go(OP_CONDITIONAL_SUB_SHIFT, 2'h0, 5'h00, 5'h02, 5'h0, 32'hBB8, 32'h0, 32'h7D0);
      sub_chk(32'hFA0, 7'h51, 1'b0);
      go(OP_CONDITIONAL_SUB_SHIFT, 2'h0, 5'h00, 5'h02, 5'h0, 32'h1, 32'h0, 32'hFFFFFFF0);
      sub_chk(32'hFFFFFFDF, 7'h51, 1'b0);
      $display("conditional subtract tests done");
      addr1_i = 24'h0982B;
      go(OP_INT_STORE, MODE_DIRECT, 5'h0, LAST_REG, 5'h0, 32'h42BD7, 32'h0, 32'h0);
      chk({mem_wr1_o.we, mem_wr1_o.addr}, {1'b1, 24'h0982B});
      chk(mem_wr1_o.data, 32'h42BD7);
      chk({mem_wr2_o.we, mem_float_o, reg_we_o}, 3'h0);
      chk(flags_we_o, 1'b0);
      go(OP_INT_STORE, 2'h3, 5'h0, 5'h04, 5'h0, 32'h1, 32'h0, 32'h0);
      chk({illegal_o, mem_wr1_o.we}, 2'h2);
      addr1_i = 24'h98AE;
      go(OP_INT_STORE_INTERLOCKED, MODE_INDIRECT, 5'h0, 5'h01, 5'h0, 32'h78D, 32'h0, 32'h0);
      chk({mem_wr1_o.data, ext_flag_pin_a_o, ext_flag_pin_b_o}, {32'h78D, 2'h3});
      valid_i = 1'b0;
      repeat (3) @(negedge ref_clk_i);
      chk({run, ext_flag_pin_a_o, ext_flag_pin_b_o}, {4'h3, 2'h0});
      addr1_i = 24'h98D3;
      addr2_i = 24'h98D3;
      go(OP_INT_STORE_DUAL, MODE_INDIRECT, 5'h0, 5'h0, 5'h05, 32'hDC, 32'h35, 32'h0);
      valid_i = 1'b0;
      @(negedge ref_clk_i);
      chk(rd, 32'h35);
      addr1_i = 24'h9835;
      addr2_i = 24'h99D3;
      go(OP_FLOAT_STORE_DUAL, MODE_INDIRECT, 5'h0, 5'h04, 5'h03, 32'h70C8000, 32'h733C000, 32'h0);
      chk({mem_float_o, mem_wr1_o.we, mem_wr2_o.we}, 3'h7);
      chk(mem_wr1_o.data, 32'h70C8000);
      chk({mem_wr1_o.addr, mem_wr2_o.addr}, {24'h9835, 24'h99D3});
      valid_i = 1'b0;
      @(negedge ref_clk_i);
      chk(rd, 32'h733C000);
      go(OP_INT_STORE_DUAL, MODE_INDIRECT, 5'h0, 5'h08, 5'h01, 32'h1, 32'h2, 32'h0);
      chk({illegal_o, mem_wr1_o.we, mem_wr2_o.we}, 3'h4);
      $display("store tests done");
      conclude();
   end
endmodule
